// File: common/supply_irq_pkg.sv
// constants for the analog supply status and interrupt flag block
package supply_irq_pkg;
    // word offsets, byte address is four times the index
    localparam logic [7:0] IDX_ANALOG_FLAG_CLEAR  = 8'h14;
    localparam logic [7:0] IDX_ANALOG_OVERVIEW    = 8'h18;
    localparam logic [7:0] IDX_SUPPLY_STATUS      = 8'h1C;
    localparam logic [7:0] IDX_SUPPLY_ENABLE      = 8'h20;
    localparam logic [7:0] IDX_SUPPLY_FLAG_CLEAR  = 8'h24;
    localparam logic [7:0] IDX_ANALOG_ENABLE      = 8'h28;
    localparam logic [9:0] ADDR_ANALOG_FLAG_CLEAR = {IDX_ANALOG_FLAG_CLEAR, 2'b00};
    localparam logic [9:0] ADDR_ANALOG_OVERVIEW   = {IDX_ANALOG_OVERVIEW, 2'b00};
    localparam logic [9:0] ADDR_SUPPLY_STATUS     = {IDX_SUPPLY_STATUS, 2'b00};
    localparam logic [9:0] ADDR_SUPPLY_ENABLE     = {IDX_SUPPLY_ENABLE, 2'b00};
    localparam logic [9:0] ADDR_SUPPLY_FLAG_CLEAR = {IDX_SUPPLY_FLAG_CLEAR, 2'b00};
    localparam logic [9:0] ADDR_ANALOG_ENABLE     = {IDX_ANALOG_ENABLE, 2'b00};
    // rail order in the four-bit condition vectors: battery, sensor, io, core
    localparam int RAILS = 4;
    // supply status register positions per rail
    localparam int POS_HIGH_LEVEL [RAILS] = '{24, 27, 28, 30};
    localparam int POS_LOW_LEVEL  [RAILS] = '{16, 19, 20, 22};
    localparam int POS_HIGH_EVENT [RAILS] = '{8, 11, 12, 14};
    localparam int POS_LOW_EVENT  [RAILS] = '{0, 3, 4, 6};
    // overview positions
    localparam int OV_LEVEL_SUMMARY  = 30;
    localparam int OV_REF_HIGH_LVL   = 29;
    localparam int OV_REF_LOW_LVL    = 28;
    localparam int OV_HEAT_STOP_LVL  = 25;
    localparam int OV_HEAT_WARN_LVL  = 24;
    localparam int OV_HIGH_SIDE_LVL  = 19;
    localparam int OV_GATE_LVL       = 18;
    localparam int OV_PUMP_LVL       = 17;
    localparam int OV_XCVR_LVL       = 16;
    localparam int OV_SUPPLY_SUMMARY = 14;
    localparam int OV_REF_HIGH       = 13;
    localparam int OV_REF_LOW        = 12;
    localparam int OV_CLOCK_MON      = 10;
    localparam int OV_HEAT_STOP      = 9;
    localparam int OV_HEAT_WARN      = 8;
    localparam int OV_HIGH_SIDE      = 3;
    localparam int OV_GATE           = 2;
    localparam int OV_PUMP           = 1;
    localparam int OV_XCVR           = 0;
    // reset values
    localparam logic [31:0] RST_ZERO          = 32'h0000_0000;
    localparam logic [7:0]  RST_SUPPLY_ENABLE = 8'hFF;
    localparam logic [3:0]  RST_ANALOG_ENABLE = 4'h0;
endpackage

// File: hw/analog_supply_irq_status.sv
// analog supply status, edge flags, overview register and supply interrupt output
`timescale 1ns/1ps
// Operation
// RQ1: overview bit 14 is OR of all supply interrupt flags
// RQ2: overview bits 13/12 flag reference over/undervoltage from converter channel 5
// RQ3: overview bit 10 shows clock watchdog interrupt flag, read only
// RQ4: overview bit 9 flags overtemperature shutdown from channel 8
// RQ5: overview bit 8 flags overtemperature prewarning, independent of shutdown
// RQ6: overview bit 3 is OR of high-side overcurrent, overheat, open-load flags
// RQ7: overview bit 2 is OR of gate driver flags
// RQ8: overview bit 1 is OR of charge pump flags
// RQ9: overview bit 0 is OR of transceiver overcurrent and overheat flags
// RQ10: reserved bits read zero, writes to them ignored
// RQ11: overview register resets to zero
// RQ12: supply status register resets to zero
// RQ13: overvoltage levels at bits 30, 28, 27, 24
// RQ14: undervoltage levels at bits 22, 20, 19, 16
// RQ15: overvoltage event flags at bits 14, 12, 11, 8
// RQ16: undervoltage event flags at bits 6, 4, 3, 0
// RQ17: supply flags capture condition edges, not levels
// RQ18: dedicated clear registers reset supply and other analog flags
// RQ19: overview bit 30 is OR of all supply level bits
// RQ20: writing one clears a flag, zero leaves it
// RQ21: combined supply interrupts drive the non-maskable interrupt output
// RQ22: each supply flag forwarded only while its enable is one
// RQ23: flag sets on rising edge, holds until cleared; level follows condition
// RQ24: hardware set wins over simultaneous software clear
module analog_supply_irq_status
    import supply_irq_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    // register port
    input  wire logic [9:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // supply conditions from supervision converter, per rail
    input  wire logic [3:0]  rail_high_in,
    input  wire logic [3:0]  rail_low_in,
    // other analog conditions
    input  wire logic        reference_high_in,
    input  wire logic        reference_low_in,
    input  wire logic        overheat_shutdown_in,
    input  wire logic        overheat_prewarn_in,
    // fault flags kept by other analog blocks
    input  wire logic        clock_monitor_flag_in,
    input  wire logic [2:0]  high_side_flags_in,
    input  wire logic [2:0]  high_side_levels_in,
    input  wire logic [7:0]  gate_driver_flags_in,
    input  wire logic [7:0]  gate_driver_levels_in,
    input  wire logic [3:0]  charge_pump_flags_in,
    input  wire logic [3:0]  charge_pump_levels_in,
    input  wire logic [1:0]  transceiver_flags_in,
    input  wire logic        transceiver_level_in,
    // interrupt outputs
    output logic             supply_nmi_out,
    output logic             analog_irq_out
);

    // synchronised conditions: 12 inputs from analog side
    localparam int NCOND = 12;
    logic [NCOND-1:0] cond_raw;
    logic [NCOND-1:0] sync1_ff;
    logic [NCOND-1:0] sync2_ff;
    logic [NCOND-1:0] prev_ff;
    logic [NCOND-1:0] rise;
    assign cond_raw = {overheat_prewarn_in, overheat_shutdown_in, reference_low_in,
                       reference_high_in, rail_low_in, rail_high_in};

    // two-stage synchroniser, analog comparators are asynchronous to mclk
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= cond_raw;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end
    assign rise = sync2_ff & ~prev_ff; // RQ17

    // bus decode
    function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
        return a == ref_a;
    endfunction
    logic wr_supply_clr;
    logic wr_analog_clr;
    assign wr_supply_clr = wr_in && hit(addr_in, ADDR_SUPPLY_FLAG_CLEAR); // RQ18
    assign wr_analog_clr = wr_in && hit(addr_in, ADDR_ANALOG_FLAG_CLEAR); // RQ18

    // level bits and event flags
    logic [3:0] high_lvl_ff;
    logic [3:0] low_lvl_ff;
    logic [3:0] high_evt_ff;
    logic [3:0] low_evt_ff;
    logic [3:0] other_lvl_ff;  // ref high, ref low, heat stop, heat warn
    logic [3:0] other_evt_ff;
    logic [3:0] other_evt_clr;
    logic [3:0] other_rise;
    logic [3:0] other_cond;
    assign other_cond    = {sync2_ff[8], sync2_ff[9], sync2_ff[10], sync2_ff[11]};
    assign other_rise    = {rise[8], rise[9], rise[10], rise[11]};
    assign other_evt_clr = wr_analog_clr ? {wdata_in[13], wdata_in[12], wdata_in[9],
                                            wdata_in[8]} : 4'h0;

    // per-rail flags; set wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < RAILS; g++) begin : g_rail
            logic clr_he;
            logic clr_le;
            assign clr_he = wr_supply_clr && wdata_in[POS_HIGH_EVENT[g]]; // RQ20
            assign clr_le = wr_supply_clr && wdata_in[POS_LOW_EVENT[g]];  // RQ20
            // level follows condition, so a status clear has nothing to hold down
            always_ff @(posedge mclk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    high_lvl_ff[g] <= 1'b0; // RQ12
                    low_lvl_ff[g]  <= 1'b0;
                end else begin
                    high_lvl_ff[g] <= sync2_ff[g]; // RQ23
                    low_lvl_ff[g]  <= sync2_ff[g+4]; // RQ23
                end
            end
            // event flags capture rising edges only
            always_ff @(posedge mclk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    high_evt_ff[g] <= 1'b0;
                    low_evt_ff[g]  <= 1'b0;
                end else begin
                    high_evt_ff[g] <= rise[g] | (high_evt_ff[g] & ~clr_he);     // RQ24
                    low_evt_ff[g]  <= rise[g+4] | (low_evt_ff[g] & ~clr_le);    // RQ24
                end
            end
        end
    endgenerate

    // other analog levels and flags
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            other_lvl_ff <= 4'h0; // RQ11
            other_evt_ff <= 4'h0;
        end else begin
            other_lvl_ff <= other_cond; // RQ23
            other_evt_ff <= other_rise | (other_evt_ff & ~other_evt_clr); // RQ2 RQ4 RQ5
        end
    end

    // enable registers
    logic [7:0] supply_en_ff;  // {hc,hi,hs,hb,lc,li,ls,lb} packed at status event positions
    logic [3:0] analog_en_ff;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            supply_en_ff <= RST_SUPPLY_ENABLE;
            analog_en_ff <= RST_ANALOG_ENABLE;
        end else begin
            if (wr_in && hit(addr_in, ADDR_SUPPLY_ENABLE)) begin
                supply_en_ff <= {wdata_in[14], wdata_in[12], wdata_in[11], wdata_in[8],
                                 wdata_in[6], wdata_in[4], wdata_in[3], wdata_in[0]};
            end
            if (wr_in && hit(addr_in, ADDR_ANALOG_ENABLE)) begin
                analog_en_ff <= {wdata_in[13], wdata_in[12], wdata_in[9], wdata_in[8]};
            end
        end
    end

    // register images; unlisted bits stay zero
    logic [31:0] supply_img;
    logic [31:0] overview_img;
    logic [31:0] supply_en_img;
    logic [31:0] analog_en_img;
    always_comb begin
        supply_img = RST_ZERO; // RQ10
        for (int i = 0; i < RAILS; i++) begin
            supply_img[POS_HIGH_LEVEL[i]] = high_lvl_ff[i]; // RQ13
            supply_img[POS_LOW_LEVEL[i]]  = low_lvl_ff[i];  // RQ14
            supply_img[POS_HIGH_EVENT[i]] = high_evt_ff[i]; // RQ15
            supply_img[POS_LOW_EVENT[i]]  = low_evt_ff[i];  // RQ16
        end
    end
    always_comb begin
        overview_img = RST_ZERO; // RQ10
        overview_img[OV_LEVEL_SUMMARY]  = |{high_lvl_ff, low_lvl_ff};     // RQ19
        overview_img[OV_REF_HIGH_LVL]   = other_lvl_ff[3];
        overview_img[OV_REF_LOW_LVL]    = other_lvl_ff[2];
        overview_img[OV_HEAT_STOP_LVL]  = other_lvl_ff[1];
        overview_img[OV_HEAT_WARN_LVL]  = other_lvl_ff[0];
        overview_img[OV_HIGH_SIDE_LVL]  = |high_side_levels_in[2:1];
        overview_img[OV_GATE_LVL]       = |gate_driver_levels_in;
        overview_img[OV_PUMP_LVL]       = |charge_pump_levels_in;
        overview_img[OV_XCVR_LVL]       = transceiver_level_in;
        overview_img[OV_SUPPLY_SUMMARY] = |{high_evt_ff, low_evt_ff};     // RQ1
        overview_img[OV_REF_HIGH]       = other_evt_ff[3];                // RQ2
        overview_img[OV_REF_LOW]        = other_evt_ff[2];                // RQ2
        overview_img[OV_CLOCK_MON]      = clock_monitor_flag_in;          // RQ3
        overview_img[OV_HEAT_STOP]      = other_evt_ff[1];                // RQ4
        overview_img[OV_HEAT_WARN]      = other_evt_ff[0];                // RQ5
        overview_img[OV_HIGH_SIDE]      = |high_side_flags_in;            // RQ6
        overview_img[OV_GATE]           = |gate_driver_flags_in;          // RQ7
        overview_img[OV_PUMP]           = |charge_pump_flags_in;          // RQ8
        overview_img[OV_XCVR]           = |transceiver_flags_in;          // RQ9
    end
    assign supply_en_img = {17'h0_0000, supply_en_ff[7], 1'b0, supply_en_ff[6:5], 2'b00,
                            supply_en_ff[4], 1'b0, supply_en_ff[3], 1'b0, supply_en_ff[2:1],
                            2'b00, supply_en_ff[0]};
    assign analog_en_img = {18'h0_0000, analog_en_ff[3:2], 2'b00, analog_en_ff[1:0], 8'h00};

    // read data one cycle after strobe, zero otherwise; clear regs read zero
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= RST_ZERO;
        end else if (rd_in) begin
            case (addr_in)
                ADDR_SUPPLY_STATUS:   rdata_out <= supply_img;
                ADDR_ANALOG_OVERVIEW: rdata_out <= overview_img;
                ADDR_SUPPLY_ENABLE:   rdata_out <= supply_en_img;
                ADDR_ANALOG_ENABLE:   rdata_out <= analog_en_img;
                default:              rdata_out <= RST_ZERO;
            endcase
        end else begin
            rdata_out <= RST_ZERO;
        end
    end

    // interrupt outputs, registered; enable gates each flag
    logic [7:0] supply_evt_vec;
    assign supply_evt_vec = {high_evt_ff[3], high_evt_ff[2], high_evt_ff[1], high_evt_ff[0],
                             low_evt_ff[3], low_evt_ff[2], low_evt_ff[1], low_evt_ff[0]};
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            supply_nmi_out <= 1'b0;
            analog_irq_out <= 1'b0;
        end else begin
            supply_nmi_out <= |(supply_evt_vec & supply_en_ff); // RQ21 RQ22
            analog_irq_out <= |(other_evt_ff & analog_en_ff);
        end
    end

    // checks
    sup_edge_set_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        rise[0] |=> high_evt_ff[0]) else $error("edge did not set flag"); // RQ17
    set_wins_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (rise[4] && wr_supply_clr && wdata_in[0]) |=> low_evt_ff[0])
        else $error("clear beat set"); // RQ24
    flag_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (high_evt_ff[3] && !(wr_supply_clr && wdata_in[14])) |=> high_evt_ff[3])
        else $error("flag dropped"); // RQ23
    flag_clear_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (wr_supply_clr && wdata_in[6] && !rise[7]) |=> !low_evt_ff[3])
        else $error("clear failed"); // RQ20
    level_follow_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        high_lvl_ff[1] == $past(sync2_ff[1])) else $error("level lag"); // RQ23
    nmi_gate_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (supply_en_ff == 8'h00) |=> !supply_nmi_out) else $error("nmi not gated"); // RQ22
    nmi_fire_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (high_evt_ff[0] && supply_en_ff[4]) |=> supply_nmi_out) else $error("nmi lost"); // RQ21
    summary_or_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (rd_in && addr_in == ADDR_ANALOG_OVERVIEW) |=>
        rdata_out[OV_SUPPLY_SUMMARY] == $past(|supply_evt_vec)) else $error("summary"); // RQ1
    reserved_zero_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        rdata_out[31] == 1'b0) else $error("reserved bit set"); // RQ10

    // read qualifiers shared by the register view checks
    logic rd_ov;
    logic rd_st;
    assign rd_ov = rd_in && hit(addr_in, ADDR_ANALOG_OVERVIEW);
    assign rd_st = rd_in && hit(addr_in, ADDR_SUPPLY_STATUS);

    // the checks below share one clock and one reset
    default clocking chk_cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    // reference and heat flags capture their own edges
    ref_high_a: assert property (rise[8] |=> other_evt_ff[3]) // RQ2
        else $error("reference high edge lost");

    ref_low_a: assert property (rise[9] |=> other_evt_ff[2]) // RQ2
        else $error("reference low edge lost");

    heat_stop_a: assert property (rise[10] |=> other_evt_ff[1]) // RQ4
        else $error("shutdown edge lost");

    heat_warn_a: assert property (rise[11] |=> other_evt_ff[0]) // RQ5
        else $error("prewarning edge lost");

    // a prewarning alone must never raise the shutdown flag
    heat_apart_a: assert property ( // RQ5
        (rise[11] && !rise[10] && !other_evt_ff[1]) |=> !other_evt_ff[1])
        else $error("prewarning set shutdown");

    // live summary bits, positions written out rather than taken from constants
    clock_view_a: assert property ( // RQ3
        rd_ov |=> rdata_out[10] == $past(clock_monitor_flag_in))
        else $error("clock monitor bit wrong");

    high_side_a: assert property ( // RQ6
        rd_ov |=> rdata_out[3] == $past(|high_side_flags_in))
        else $error("high side summary wrong");

    gate_or_a: assert property ( // RQ7
        rd_ov |=> rdata_out[2] == $past(|gate_driver_flags_in))
        else $error("gate driver summary wrong");

    pump_or_a: assert property ( // RQ8
        rd_ov |=> rdata_out[1] == $past(|charge_pump_flags_in))
        else $error("charge pump summary wrong");

    xcvr_or_a: assert property ( // RQ9
        rd_ov |=> rdata_out[0] == $past(|transceiver_flags_in))
        else $error("transceiver summary wrong");

    level_sum_a: assert property ( // RQ19
        rd_ov |=> rdata_out[30] == $past(|{high_lvl_ff, low_lvl_ff}))
        else $error("level summary wrong");

    // reserved places of both status views read zero
    over_resv_a: assert property ( // RQ10
        rd_ov |=> (rdata_out & ~32'h730F_770F) == 32'h0000_0000)
        else $error("overview reserved bit set");

    stat_resv_a: assert property ( // RQ10
        rd_st |=> (rdata_out & ~32'h5959_5959) == 32'h0000_0000)
        else $error("status reserved bit set");

    // sensor rail lands on its own status places
    high_pos_a: assert property ( // RQ13
        rd_st |=> rdata_out[27] == $past(high_lvl_ff[1]))
        else $error("high level misplaced");

    low_pos_a: assert property ( // RQ14
        rd_st |=> rdata_out[19] == $past(low_lvl_ff[1]))
        else $error("low level misplaced");

    high_event_a: assert property ( // RQ15
        rd_st |=> rdata_out[11] == $past(high_evt_ff[1]))
        else $error("high event misplaced");

    low_event_a: assert property ( // RQ16
        rd_st |=> rdata_out[3] == $past(low_evt_ff[1]))
        else $error("low event misplaced");

    // flag lifetime and clear handling
    low_edge_a: assert property (rise[4] |=> low_evt_ff[0]) // RQ17
        else $error("low edge did not set flag");

    other_hold_a: assert property ( // RQ23
        (other_evt_ff[2] && !other_evt_clr[2]) |=> other_evt_ff[2])
        else $error("analog flag dropped");

    other_wins_a: assert property ( // RQ24
        (rise[10] && other_evt_clr[1]) |=> other_evt_ff[1])
        else $error("analog clear beat set");

    other_clear_a: assert property ( // RQ18
        (other_evt_clr[0] && !rise[11]) |=> !other_evt_ff[0])
        else $error("analog clear failed");

    core_nmi_a: assert property ( // RQ21
        (low_evt_ff[3] && supply_en_ff[3]) |=> supply_nmi_out)
        else $error("core low event not forwarded");

    ref_follow_a: assert property (other_lvl_ff[3] == $past(sync2_ff[8])) // RQ23
        else $error("reference level lag");

    low_follow_a: assert property (low_lvl_ff[2] == $past(sync2_ff[6])) // RQ23
        else $error("io low level lag");

    ref_edge_c: cover property (rise[8]);
    analog_irq_c: cover property ($rose(analog_irq_out));
    sup_edge_c: cover property (@(posedge mclk_in) disable iff (!nrst_in) rise[3]);
    sup_clear_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        high_evt_ff[0] ##1 !high_evt_ff[0]);
    nmi_c: cover property (@(posedge mclk_in) disable iff (!nrst_in) $rose(supply_nmi_out));
endmodule

// File: dv/core_bus_model.sv
// processor core model: issues register cycles on the block's plain port
`timescale 1ns/1ps
module core_bus_model (
    // clock
    input  wire logic        mclk_in,
    // register port towards the block
    output logic      [9:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    input  wire logic [31:0] rdata_in
);
    // idle bus from time zero so no strobe is ever unknown
    initial begin
        addr_out  = 10'h000;
        wdata_out = 32'h0000_0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // one write cycle; clears are sent as ones on the flags to clear
    task automatic bus_write(input logic [9:0] addr, input logic [31:0] data);
        @(posedge mclk_in);
        addr_out  <= addr;
        wdata_out <= data;
        wr_out    <= 1'b1;
        @(posedge mclk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~data; // stale data must not look valid
    endtask

    // one read cycle; data stand only in the cycle after the strobe
    task automatic bus_read(input logic [9:0] addr, output logic [31:0] data);
        @(posedge mclk_in);
        addr_out <= addr;
        rd_out   <= 1'b1;
        @(posedge mclk_in);
        rd_out   <= 1'b0;
        #1;
        data = rdata_in;
    endtask
endmodule

// File: dv/analog_supply_irq_status_bench.sv
// self-checking bench for the supply status and analog flag block
`timescale 1ns/1ps
module analog_supply_irq_status_bench;
    import supply_irq_pkg::*;
    logic        mclk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] got;
    logic        wr;
    logic        rd;
    logic [3:0]  rail_high = 4'h0;
    logic [3:0]  rail_low = 4'h0;
    logic [3:0]  ana = 4'h0;
    logic [33:0] misc = '0;
    logic        nmi;
    logic        irq;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 91;
    // positions of the reference and heat flags, same order as ana
    int          evt_pos [4] = '{OV_REF_HIGH, OV_REF_LOW, OV_HEAT_STOP, OV_HEAT_WARN};
    int          lvl_pos [4] = '{OV_REF_HIGH_LVL, OV_REF_LOW_LVL,
                                 OV_HEAT_STOP_LVL, OV_HEAT_WARN_LVL};

    // 25 ns clock
    always #12.5 mclk_in = ~mclk_in;

    core_bus_model core (.mclk_in(mclk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
                         .rd_out(rd), .rdata_in(rdata));

    analog_supply_irq_status dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .rail_high_in(rail_high), .rail_low_in(rail_low), .reference_high_in(ana[3]),
        .reference_low_in(ana[2]), .overheat_shutdown_in(ana[1]), .overheat_prewarn_in(ana[0]),
        .clock_monitor_flag_in(misc[33]), .high_side_flags_in(misc[32:30]),
        .high_side_levels_in(misc[29:27]), .gate_driver_flags_in(misc[26:19]),
        .gate_driver_levels_in(misc[18:11]), .charge_pump_flags_in(misc[10:7]),
        .charge_pump_levels_in(misc[6:3]), .transceiver_flags_in(misc[2:1]),
        .transceiver_level_in(misc[0]), .supply_nmi_out(nmi), .analog_irq_out(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        core.bus_read(a, got);
        check(got, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // overview bits fed live by the other analog blocks
    function automatic logic [31:0] fault_view(input logic [33:0] m);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[OV_HIGH_SIDE_LVL] = |m[29:28];
        v[OV_GATE_LVL] = |m[18:11];
        v[OV_PUMP_LVL] = |m[6:3];
        v[OV_XCVR_LVL] = m[0];
        v[OV_CLOCK_MON] = m[33];
        v[OV_HIGH_SIDE] = |m[32:30];
        v[OV_GATE] = |m[26:19];
        v[OV_PUMP] = |m[10:7];
        v[OV_XCVR] = |m[2:1];
        return v;
    endfunction

    // one rail, one direction: level follows, event holds until cleared
    task automatic rail_pass(input int r, input bit hi);
        logic [31:0] lvl;
        logic [31:0] evt;
        lvl = 32'h1 << (hi ? POS_HIGH_LEVEL[r] : POS_LOW_LEVEL[r]);
        evt = 32'h1 << (hi ? POS_HIGH_EVENT[r] : POS_LOW_EVENT[r]);
        @(posedge mclk_in);
        if (hi) rail_high[r] <= 1'b1;
        else rail_low[r] <= 1'b1;
        wait_cyc(6);
        check(nmi, 1'b1);
        rd_chk(ADDR_SUPPLY_STATUS, lvl | evt);
        rd_chk(ADDR_ANALOG_OVERVIEW, 32'h4000_4000);
        rail_high[r] <= 1'b0;
        rail_low[r] <= 1'b0;
        wait_cyc(6);
        rd_chk(ADDR_SUPPLY_STATUS, evt);
        core.bus_write(ADDR_SUPPLY_FLAG_CLEAR, ~evt);
        rd_chk(ADDR_SUPPLY_STATUS, evt);
        core.bus_write(ADDR_SUPPLY_FLAG_CLEAR, evt);
        rd_chk(ADDR_SUPPLY_STATUS, 32'h0000_0000);
        wait_cyc(2);
        check(nmi, 1'b0);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 4000 cycles
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end

    initial begin
        logic [31:0] ev;
        logic [63:0] rnd;
        wait_cyc(20);
        nrst_in <= 1'b1;
        rd_chk(ADDR_SUPPLY_ENABLE, 32'h0000_5959);
        rd_chk(ADDR_ANALOG_OVERVIEW, RST_ZERO);
        rd_chk(ADDR_SUPPLY_STATUS, RST_ZERO);
        for (int i = 0; i < 2 * RAILS; i++) begin
            rail_pass(i % RAILS, i < RAILS);
        end
        // masked supply event is kept but not forwarded
        core.bus_write(ADDR_SUPPLY_ENABLE, 32'h0000_0000);
        rail_low[0] <= 1'b1;
        wait_cyc(6);
        check(nmi, 1'b0);
        core.bus_write(ADDR_SUPPLY_ENABLE, 32'h0000_0001);
        wait_cyc(2);
        check(nmi, 1'b1);
        rail_low[0] <= 1'b0;
        wait_cyc(6);
        // reset in mid-run with an event still pending
        nrst_in <= 1'b0;
        wait_cyc(2);
        nrst_in <= 1'b1;
        rd_chk(ADDR_SUPPLY_STATUS, RST_ZERO);
        // reference and heat conditions, one at a time
        for (int k = 0; k < 4; k++) begin
            ev = 32'h1 << evt_pos[k];
            ana <= 4'h8 >> k;
            wait_cyc(6);
            rd_chk(ADDR_ANALOG_OVERVIEW, ev | (32'h1 << lvl_pos[k]));
            check(irq, 1'b0);
            core.bus_write(ADDR_ANALOG_ENABLE, ev);
            wait_cyc(2);
            check(irq, 1'b1);
            core.bus_write(ADDR_ANALOG_ENABLE, 32'h0000_0000);
            ana <= 4'h0;
            wait_cyc(6);
            rd_chk(ADDR_ANALOG_OVERVIEW, ev);
            core.bus_write(ADDR_ANALOG_FLAG_CLEAR, ev);
            rd_chk(ADDR_ANALOG_OVERVIEW, 32'h0000_0000);
        end
        // random fault flags from the other blocks, first pass all quiet
        for (int j = 0; j < 24; j++) begin
            @(posedge mclk_in);
            rnd = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
            misc <= (j == 0) ? 34'h0 : rnd[33:0];
            wait_cyc(2);
            rd_chk(ADDR_ANALOG_OVERVIEW, fault_view(misc));
        end
        misc <= '0;
        // read-only overview, unmapped place and clear register read zero
        core.bus_write(ADDR_ANALOG_OVERVIEW, 32'hFFFF_FFFF);
        rd_chk(ADDR_ANALOG_OVERVIEW, 32'h0000_0000);
        core.bus_write(10'h3FC, 32'hFFFF_FFFF);
        rd_chk(10'h3FC, 32'h0000_0000);
        rd_chk(ADDR_SUPPLY_FLAG_CLEAR, 32'h0000_0000);
        print_verdict();
    end
endmodule
